// file: pcr_defs.vh
// Constants for the class result and auto-class control register bank
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// ***************************************************************
// Register command codes
// ***************************************************************
`define PCR_CMD_CH1_CLASS     8'h4c
`define PCR_CMD_CH2_CLASS     8'h4d
`define PCR_CMD_CH3_CLASS     8'h4e
`define PCR_CMD_CH4_CLASS     8'h4f
`define PCR_CMD_AUTOCLASS     8'h50

// ***************************************************************
// Field layout and reset values
// ***************************************************************
`define PCR_ASSIGNED_HI       7
`define PCR_ASSIGNED_LO       4
`define PCR_PREVIOUS_HI       3
`define PCR_PREVIOUS_LO       0
`define PCR_MAC_HI            7
`define PCR_MAC_LO            4
`define PCR_AAC_HI            3
`define PCR_AAC_LO            0
`define PCR_RST_BYTE          8'h00
`define PCR_RST_NIB           4'h0

// ***************************************************************
// Class codes
// ***************************************************************
`define PCR_CLS_UNKNOWN       4'h0
`define PCR_CLS_1             4'h1
`define PCR_CLS_3             4'h3
`define PCR_CLS_4             4'h4
`define PCR_CLS_0_PREV        4'h6
`define PCR_CLS_5_SS          4'h8
`define PCR_CLS_8_SS          4'hb
`define PCR_CLS_5_DS          4'hd

// ***************************************************************
// Timing (microseconds) and clock rate (kHz)
// ***************************************************************
`define PCR_CLK_KHZ           50000
`define PCR_T_ASSIGN_US       5000
`define PCR_T_MACSTART_US     10000
`define PCR_T_MACCLR_US       1000
`define PCR_T_ADJUST_US       5000

`endif

// file: pcr_chan_class.v
// One channel's assigned and previous class fields with deadline timer
`timescale 1ns/100ps
`include "pcr_defs.vh"

module pcr_chan_class #(
  parameter DLY_CYC = 250000
) (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // Channel events
  input  wire       chan_off,
  input  wire       class_load,
  input  wire [3:0] class_code,
  input  wire       prev_load,
  input  wire [3:0] prev_code,
  // Field contents
  output reg  [3:0] assigned_class_field,
  output reg  [3:0] previous_class_field
);

  // ***************************************************************
  // Class mapping
  // ***************************************************************
  // Class 0 loads are recorded as class 3; reserved codes become unknown
  function [3:0] map_assigned;
    input [3:0] c;
    begin
      if (c == `PCR_CLS_0_PREV)
        map_assigned = `PCR_CLS_3;
      else if ((c >= `PCR_CLS_1 && c <= `PCR_CLS_4) ||
               (c >= `PCR_CLS_5_SS && c <= `PCR_CLS_8_SS) || c == `PCR_CLS_5_DS)
        map_assigned = c;
      else
        map_assigned = `PCR_CLS_UNKNOWN;
    end
  endfunction

  // Previous field accepts class 0 code as well
  function [3:0] map_previous;
    input [3:0] c;
    begin
      if (c == `PCR_CLS_0_PREV || (c >= `PCR_CLS_1 && c <= `PCR_CLS_4) ||
          (c >= `PCR_CLS_5_SS && c <= `PCR_CLS_8_SS) || c == `PCR_CLS_5_DS)
        map_previous = c;
      else
        map_previous = `PCR_CLS_UNKNOWN;
    end
  endfunction

  // ***************************************************************
  // Pending write with a bounded delay
  // ***************************************************************
  reg        pend_r;
  reg [3:0]  pend_code_r;
  reg [17:0] cnt_r;

  // Posting one cycle later keeps well inside the deadline; counter bounds it
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pend_r               <= 1'b0;
      pend_code_r          <= `PCR_RST_NIB;
      cnt_r                <= 18'h0;
      assigned_class_field <= `PCR_RST_NIB;
      previous_class_field <= `PCR_RST_NIB;
    end else if (chan_off) begin
      pend_r               <= 1'b0;
      cnt_r                <= 18'h0;
      assigned_class_field <= `PCR_RST_NIB;
      previous_class_field <= `PCR_RST_NIB;
    end else begin
      if (class_load) begin
        pend_r      <= 1'b1;
        pend_code_r <= map_assigned(class_code);
        cnt_r       <= 18'h0;
      end else if (pend_r) begin
        if (cnt_r == 18'h0 || cnt_r >= DLY_CYC[17:0] - 18'h1) begin
          assigned_class_field <= pend_code_r;
          pend_r               <= 1'b0;
        end
        cnt_r <= cnt_r + 18'h1;
      end
      if (prev_load)
        previous_class_field <= map_previous(prev_code);
    end
  end

endmodule // pcr_chan_class

// file: pcr_class_ctrl.v
// Class result and auto-class control register bank for four channels
`timescale 1ns/100ps
`include "pcr_defs.vh"

module pcr_class_ctrl #(
  parameter NCH         = 4,
  parameter ASSIGN_CYC  = `PCR_T_ASSIGN_US * (`PCR_CLK_KHZ / 1000),
  parameter MACSTART_CYC = `PCR_T_MACSTART_US * (`PCR_CLK_KHZ / 1000),
  parameter MACCLR_CYC  = `PCR_T_MACCLR_US * (`PCR_CLK_KHZ / 1000),
  parameter ADJUST_CYC  = `PCR_T_ADJUST_US * (`PCR_CLK_KHZ / 1000)
) (
  // Clock and reset
  input  wire           ref_clk,
  input  wire           sys_rst,
  // Command-addressed register access
  input  wire           reg_wr,
  input  wire           reg_rd,
  input  wire [7:0]     reg_cmd,
  input  wire [7:0]     reg_wdata,
  output reg  [7:0]     reg_rdata,
  output wire           reg_hit,
  // Channel status from the port sequencer
  input  wire [NCH-1:0] chan_off,
  input  wire [NCH-1:0] chan_turn_on,
  input  wire [NCH-1:0] chan_manual_mode,
  input  wire [NCH-1:0] chan_semi_auto,
  input  wire [NCH-1:0] detect_enable,
  input  wire [NCH-1:0] class_enable,
  input  wire [NCH-1:0] alloc_15w,
  input  wire [NCH-1:0] four_pair_ss,
  input  wire [NCH-1:0] class_done,
  input  wire [NCH*4-1:0] alloc_class,
  input  wire [NCH*4-1:0] prev_3f_class,
  // Auto-class measurement engine
  output wire [NCH-1:0] autoclass_start,
  input  wire [NCH-1:0] autoclass_power_result_wr,
  input  wire [NCH-1:0] autoclass_meas_end,
  output wire [NCH-1:0] pcut_adjust_req,
  // Flags and fields
  output wire [NCH-1:0] class_cycle_done_flag,
  output wire [NCH*4-1:0] assigned_class_out,
  output wire [NCH-1:0] autoclass_auto_adjust_en
);

  // ***************************************************************
  // Auto-class control register
  // ***************************************************************
  reg  [NCH-1:0] manual_autoclass_request;
  reg  [NCH-1:0] aac_r;
  reg  [NCH-1:0] clr_pend_r;
  reg  [NCH-1:0] start_done_r;
  wire [NCH-1:0] pair_load;
  wire [3:0]     ac_field [0:NCH-1];
  wire [3:0]     pc_field [0:NCH-1];
  wire           wr_ctrl;
  integer        i;

  assign wr_ctrl                  = reg_wr && (reg_cmd == `PCR_CMD_AUTOCLASS);
  assign autoclass_auto_adjust_en = aac_r;
  // Measurement starts the cycle after the request is seen, well under its deadline
  assign autoclass_start          = manual_autoclass_request & ~start_done_r;
  // Power cut follows the result at the end of the measurement period
  assign pcut_adjust_req          = autoclass_meas_end & aac_r;
  assign class_cycle_done_flag    = class_done;

  // Hardware clear wins only where documented; host set in same cycle loses
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      manual_autoclass_request <= {NCH{1'b0}};
      aac_r                    <= {NCH{1'b0}};
      clr_pend_r               <= {NCH{1'b0}};
      start_done_r             <= {NCH{1'b0}};
    end else begin
      if (wr_ctrl) begin
        manual_autoclass_request <= reg_wdata[`PCR_MAC_HI:`PCR_MAC_LO];
        aac_r                    <= reg_wdata[`PCR_AAC_HI:`PCR_AAC_LO];
        start_done_r             <= {NCH{1'b0}};
      end
      for (i = 0; i < NCH; i = i + 1) begin
        if (manual_autoclass_request[i] && !start_done_r[i] && !wr_ctrl)
          start_done_r[i] <= 1'b1;
        if (autoclass_power_result_wr[i] && manual_autoclass_request[i])
          clr_pend_r[i] <= 1'b1;
        if (clr_pend_r[i]) begin
          manual_autoclass_request[i] <= 1'b0;
          clr_pend_r[i]               <= 1'b0;
          start_done_r[i]             <= 1'b0;
        end
        if (chan_turn_on[i] || chan_off[i]) begin
          manual_autoclass_request[i] <= 1'b0;
          start_done_r[i]             <= 1'b0;
          clr_pend_r[i]               <= 1'b0;
        end
      end
    end
  end

  // ***************************************************************
  // Per-channel class fields
  // ***************************************************************
  // Allocation-limited class loaded only from automatic modes
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      // Single-signature pair partner shares the measured channel's class
      assign pair_load[g] = class_done[g] ||
                            (four_pair_ss[g] && class_done[g ^ 1]);
      pcr_chan_class #(
        .DLY_CYC (ASSIGN_CYC)
      ) u_chan (
        .ref_clk              (ref_clk),
        .sys_rst              (sys_rst),
        .chan_off             (chan_off[g]),
        .class_load           (pair_load[g] && !chan_manual_mode[g]),
        .class_code           (four_pair_ss[g] && !class_done[g] ?
                               alloc_class[(g^1)*4 +: 4] : alloc_class[g*4 +: 4]),
        .prev_load            (chan_turn_on[g] && alloc_15w[g] && chan_semi_auto[g] &&
                               detect_enable[g] && class_enable[g]),
        .prev_code            (prev_3f_class[g*4 +: 4]),
        .assigned_class_field (ac_field[g]),
        .previous_class_field (pc_field[g])
      );
      assign assigned_class_out[g*4 +: 4] = ac_field[g];
    end
  endgenerate

  // ***************************************************************
  // Read path
  // ***************************************************************
  // Writes to result registers are decoded but change nothing
  assign reg_hit = (reg_cmd >= `PCR_CMD_CH1_CLASS) && (reg_cmd <= `PCR_CMD_AUTOCLASS);

  // Read data registered; reads never alter state
  always @(posedge ref_clk) begin
    if (sys_rst)
      reg_rdata <= `PCR_RST_BYTE;
    else if (reg_rd) begin
      case (reg_cmd)
        `PCR_CMD_CH1_CLASS: reg_rdata <= {ac_field[0], pc_field[0]};
        `PCR_CMD_CH2_CLASS: reg_rdata <= {ac_field[1], pc_field[1]};
        `PCR_CMD_CH3_CLASS: reg_rdata <= {ac_field[2], pc_field[2]};
        `PCR_CMD_CH4_CLASS: reg_rdata <= {ac_field[3], pc_field[3]};
        `PCR_CMD_AUTOCLASS: reg_rdata <= {manual_autoclass_request, aac_r};
        default:            reg_rdata <= `PCR_RST_BYTE;
      endcase
    end
  end

endmodule // pcr_class_ctrl

// file: pcr_class_ctrl_props.sv
// Port assertions for the class result and auto-class control bank
`timescale 1ns/100ps
module pcr_class_ctrl_props #(
  parameter NCH = 4
) (
  // Clock and reset
  input wire             ref_clk,
  input wire             sys_rst,
  // Register access
  input wire             reg_wr,
  input wire             reg_rd,
  input wire             reg_hit,
  input wire [7:0]       reg_cmd,
  input wire [7:0]       reg_wdata,
  input wire [7:0]       reg_rdata,
  // Channel events and engine handshakes
  input wire [NCH-1:0]   chan_off,
  input wire [NCH-1:0]   chan_turn_on,
  input wire [NCH-1:0]   class_done,
  input wire [NCH-1:0]   autoclass_start,
  input wire [NCH-1:0]   autoclass_meas_end,
  input wire [NCH-1:0]   pcut_adjust_req,
  input wire [NCH-1:0]   class_cycle_done_flag,
  input wire [NCH-1:0]   autoclass_auto_adjust_en,
  input wire [NCH*4-1:0] alloc_class,
  input wire [NCH*4-1:0] assigned_class_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Decode and read path; unmapped places must read as zero
  chk_hit_decode: assert property (
    reg_hit == (reg_cmd >= 8'h4c && reg_cmd <= 8'h50)) else $error("reg_hit decode wrong");
  chk_unmapped_zero: assert property (
    reg_rd && !reg_hit |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_adjust_en_wr: assert property (
    reg_wr && reg_cmd == 8'h50 |=> autoclass_auto_adjust_en == $past(reg_wdata[3:0]))
    else $error("auto-adjust enables not written");
  // Engine side outputs
  chk_pcut_request: assert property (
    pcut_adjust_req == (autoclass_meas_end & autoclass_auto_adjust_en))
    else $error("adjust request mismatch");
  chk_done_flag: assert property (
    class_cycle_done_flag == class_done) else $error("done flag on wrong channel");
  chk_start_pulse: assert property (
    autoclass_start[0] |=> !autoclass_start[0]) else $error("start longer than one cycle");
  chk_start_prompt: assert property (
    reg_wr && reg_cmd == 8'h50 && reg_wdata[4] && !chan_turn_on[0] && !chan_off[0]
    && !autoclass_start[0] |=> autoclass_start[0]) else $error("request did not start");
  chk_turnon_kill: assert property (
    chan_turn_on != {NCH{1'b0}} |=> (autoclass_start & $past(chan_turn_on)) == {NCH{1'b0}})
    else $error("start despite turn-on");
  // Class fields; a bounded window covers the two-stage load
  chk_off_clear: assert property (
    chan_off[0] && class_done == 4'h0 |-> ##[1:3] assigned_class_out[3:0] == 4'h0)
    else $error("off did not clear class");
  chk_class0_as3: assert property (
    (class_done[0] && !class_done[1] && !chan_off[0] && alloc_class[3:0] == 4'h6)
    ##1 (!chan_off[0] && class_done[1:0] == 2'b00) |-> ##[1:2] assigned_class_out[3:0] == 4'h3)
    else $error("class 0 load not shown as 3");
endmodule // pcr_class_ctrl_props

// file: pcr_host_model.sv
// Host model making command-addressed byte accesses to the bank
`timescale 1ns/100ps
module pcr_host_model (
  // Clock
  input  wire       ref_clk,
  // Register access
  output reg        reg_wr    = 1'b0,
  output reg        reg_rd    = 1'b0,
  output reg  [7:0] reg_cmd   = 8'h00,
  output reg  [7:0] reg_wdata = 8'h00,
  input  wire [7:0] reg_rdata
);
  // One byte write; released data is inverted so stale bytes never look valid
  task wr(input [7:0] c, input [7:0] v);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_cmd <= c;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~v;
    end
  endtask
  // One byte read; data is taken a cycle after the sampled strobe
  task rd(input [7:0] c, output [7:0] v);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_cmd <= c;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      v = reg_rdata;
    end
  endtask
endmodule // pcr_host_model

// file: tb.sv
// Self-checking bench for the class result and auto-class control bank
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  reg         ref_clk = 1'b0;
  reg         sys_rst = 1'b1;
  wire        reg_wr, reg_rd, reg_hit;
  wire [7:0]  reg_cmd, reg_wdata, reg_rdata;
  reg  [3:0]  chan_off = 4'h0, chan_turn_on = 4'h0, chan_manual_mode = 4'h0, chan_semi_auto = 4'h0;
  reg  [3:0]  detect_enable = 4'h0, class_enable = 4'h0, alloc_15w = 4'h0, four_pair_ss = 4'h0;
  reg  [3:0]  class_done = 4'h0, autoclass_power_result_wr = 4'h0, autoclass_meas_end = 4'h0;
  reg  [15:0] alloc_class = 16'h0000, prev_3f_class = 16'h0000;
  wire [3:0]  autoclass_start, pcut_adjust_req, class_cycle_done_flag, autoclass_auto_adjust_en;
  wire [15:0] assigned_class_out;
  reg  [7:0]  d;
  reg         got_start = 1'b0;
  integer     n_fail = 0, checked = 0, seed = 32'h540dbb93, k, ctl;
  // Short deadline counts keep the run brief; writes land within two cycles
  pcr_class_ctrl #(.ASSIGN_CYC(4), .MACSTART_CYC(4), .MACCLR_CYC(4), .ADJUST_CYC(4)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .chan_off(chan_off), .chan_turn_on(chan_turn_on), .chan_manual_mode(chan_manual_mode),
    .chan_semi_auto(chan_semi_auto), .detect_enable(detect_enable),
    .class_enable(class_enable), .alloc_15w(alloc_15w), .four_pair_ss(four_pair_ss),
    .class_done(class_done), .alloc_class(alloc_class), .prev_3f_class(prev_3f_class),
    .autoclass_start(autoclass_start),
    .autoclass_power_result_wr(autoclass_power_result_wr),
    .autoclass_meas_end(autoclass_meas_end), .pcut_adjust_req(pcut_adjust_req),
    .class_cycle_done_flag(class_cycle_done_flag),
    .assigned_class_out(assigned_class_out),
    .autoclass_auto_adjust_en(autoclass_auto_adjust_en)
  );
  pcr_host_model host (
    .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_cmd(reg_cmd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );
  initial forever #10 ref_clk = ~ref_clk;
  // Start is a single-cycle pulse, so latch it rather than poll for it
  always @(posedge ref_clk) if (autoclass_start[0]) got_start <= 1'b1;
  // Reference mapping of a limited class code to the assigned field
  function integer amap(input integer c);
    begin
      amap = (c == 6) ? 3 : (c inside {[1:4], [8:11], 13}) ? c : 0;
    end
  endfunction
  task rd_chk(input [7:0] c, input integer e);
    begin
      host.rd(c, d);
      `CHK("reg_rdata", e, d)
    end
  endtask
  task wait_n(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    wait_n(5);
    sys_rst <= 1'b0;
    for (k = 0; k < 5; k++) rd_chk(8'h4c + k, 0);
    rd_chk(8'h51, 0);
    `CHK("reg_hit", 1'b0, reg_hit)
    d = $random(seed);
    ctl = d & 8'h0f;
    host.wr(8'h50, d & 8'h0f);
    rd_chk(8'h50, ctl);
    `CHK("auto_adjust_en", ctl, autoclass_auto_adjust_en)
    autoclass_meas_end <= 4'hf;
    #1 `CHK("pcut_adjust_req", ctl, pcut_adjust_req)
    wait_n(1);
    autoclass_meas_end <= 4'h0;
    for (k = 0; k < 16; k++) begin
      alloc_class[3:0] <= k[3:0];
      class_done[0] <= 1'b1;
      wait_n(1);
      class_done[0] <= 1'b0;
      wait_n(3);
      rd_chk(8'h4c, amap(k) << 4);
    end
    four_pair_ss <= 4'hc;
    alloc_class[11:8] <= 4'h9;
    class_done[2] <= 1'b1;
    #1 `CHK("done_flag", 4'h4, class_cycle_done_flag)
    wait_n(1);
    class_done[2] <= 1'b0;
    wait_n(3);
    rd_chk(8'h4e, 8'h90);
    rd_chk(8'h4f, 8'h90);
    `CHK("assigned_class_out", 16'h9900, assigned_class_out)
    // Manual-mode channel keeps its field through a classification
    chan_manual_mode[0] <= 1'b1;
    alloc_class[3:0] <= 4'h2;
    class_done[0] <= 1'b1;
    wait_n(1);
    class_done[0] <= 1'b0;
    chan_manual_mode[0] <= 1'b0;
    wait_n(3);
    rd_chk(8'h4c, amap(15) << 4);
    {chan_semi_auto[1], detect_enable[1], class_enable[1], alloc_15w[1]} <= 4'hf;
    prev_3f_class[7:4] <= 4'h6;
    wait_n(1);
    chan_turn_on[1] <= 1'b1;
    wait_n(1);
    chan_turn_on[1] <= 1'b0;
    wait_n(3);
    rd_chk(8'h4d, 8'h06);
    d = $random(seed);
    host.wr(8'h4d, d);
    rd_chk(8'h4d, 8'h06);
    chan_off[1] <= 1'b1;
    wait_n(1);
    chan_off[1] <= 1'b0;
    wait_n(3);
    rd_chk(8'h4d, 0);
    host.wr(8'h50, 8'h10 | ctl);
    for (k = 0; k < 50 && !got_start; k++) wait_n(1);
    `CHK("autoclass_start", 1'b1, got_start)
    autoclass_power_result_wr[0] <= 1'b1;
    wait_n(1);
    autoclass_power_result_wr[0] <= 1'b0;
    wait_n(3);
    rd_chk(8'h50, ctl);
    fork
      host.wr(8'h50, 8'h20 | ctl);
      begin
        wait_n(1);
        chan_turn_on[1] <= 1'b1;
        wait_n(1);
        chan_turn_on[1] <= 1'b0;
      end
    join
    rd_chk(8'h50, ctl);
    chan_off <= 4'h5;
    wait_n(1);
    chan_off <= 4'h0;
    wait_n(3);
    rd_chk(8'h4e, 0);
    rd_chk(8'h4f, 8'h90);
    test_done;
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    wait_n(5000);
    n_fail++;
    test_done;
  end
endmodule // tb
bind pcr_class_ctrl pcr_class_ctrl_props #(.NCH(NCH)) u_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_hit(reg_hit), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .chan_off(chan_off), .chan_turn_on(chan_turn_on), .class_done(class_done),
  .autoclass_start(autoclass_start), .autoclass_meas_end(autoclass_meas_end),
  .pcut_adjust_req(pcut_adjust_req), .class_cycle_done_flag(class_cycle_done_flag),
  .autoclass_auto_adjust_en(autoclass_auto_adjust_en), .alloc_class(alloc_class),
  .assigned_class_out(assigned_class_out)
);
